// ---- shared/slogr_pkg.sv ----
// Constants, types and register map of the source event logger
package slogr_pkg;

  // ==========================================================
  // Timing and sizes
  localparam int CLK_MHZ = 125;
  localparam int NUM_EV = 22;
  localparam int LOG_DEPTH_DEF = 99;
  localparam int LCD_DEPTH_DEF = 20;
  localparam logic [7:0] NLOSS_PCT = 8'h14;
  localparam logic [7:0] UNBAL_THR_RST = 8'h05;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] REG_ENABLE = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_SEL_LCD = 8'h0C;
  localparam logic [7:0] REG_SEL_MB = 8'h10;
  localparam logic [7:0] REG_LOG_TS = 8'h14;
  localparam logic [7:0] REG_LOG_INFO = 8'h18;

  // Field positions
  localparam int CFG_THR_LSB = 0;
  localparam int CFG_NSEQ_LSB = 8;
  localparam int STAT_COUNT_LSB = 0;
  localparam int STAT_WARN31_BIT = 8;
  localparam int STAT_LED0_LSB = 12;
  localparam int STAT_LED1_LSB = 14;
  localparam int INFO_CODE_LSB = 0;
  localparam int INFO_STAT_LSB = 8;
  localparam int INFO_MODE_LSB = 16;
  localparam int INFO_VALID_BIT = 31;

  // ==========================================================
  // Event indices; from EV_UNBAL on, pairs are source one then source two
  localparam int EV_GEN_LOST = 0;
  localparam int EV_GEN_FAIL = 1;
  localparam int EV_ONLOAD = 2;
  localparam int EV_OFFLOAD = 3;
  localparam int EV_UNBAL = 4;
  localparam int EV_NSEQ = 6;
  localparam int EV_NLOSS = 8;
  localparam int EV_UV = 10;
  localparam int EV_OV = 12;
  localparam int EV_NOV = 14;
  localparam int EV_UF = 16;
  localparam int EV_OF = 18;
  localparam int EV_REC = 20;

  localparam logic [7:0] CODE_GEN_LOST = 8'h1E;
  localparam logic [7:0] CODE_TEST = 8'h28;
  localparam logic [7:0] CODE_UNBAL = 8'h32;
  localparam logic [7:0] CODE_NSEQ = 8'h34;
  localparam logic [7:0] CODE_NLOSS = 8'h36;
  localparam logic [7:0] CODE_UV = 8'h46;
  localparam logic [7:0] CODE_OV = 8'h48;
  localparam logic [7:0] CODE_NOV = 8'h4A;
  localparam logic [7:0] CODE_UF = 8'h4C;
  localparam logic [7:0] CODE_OF = 8'h4E;
  localparam logic [7:0] CODE_REC = 8'h50;

  localparam logic [NUM_EV-1:0] ALWAYS_MASK = 22'h30CC0C;
  localparam logic [NUM_EV-1:0] ENABLE_RST = 22'h30CCCC;
  localparam logic [NUM_EV-1:0] POPUP_MASK = 22'h0000FF;
  localparam logic [NUM_EV-1:0] BLINK_MASK = 22'h0F3F00;
  localparam logic [NUM_EV-1:0] OFF_MASK = 22'h00C000;
  localparam logic [NUM_EV-1:0] ON_MASK = 22'h300000;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {SLOGR_LED_OFF, SLOGR_LED_ON, SLOGR_LED_BLINK} slogr_led_t;

  typedef struct packed {
    logic [7:0] unbal_pct;
    logic connected;
    logic neutral_seq;
    logic undervolt;
    logic overvolt;
    logic no_volt;
    logic underfreq;
    logic overfreq;
    logic recovered;
    logic in_range;
  } slogr_src_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } slogr_req_t;

  typedef struct packed {
    logic [31:0] ts;
    logic [7:0] code;
    logic [3:0] src_status;
    logic [2:0] mode;
  } slogr_entry_t;

  typedef struct packed {
    logic [NUM_EV-1:0] en;
    logic [7:0] thr;
    logic [1:0] nseq_cfg;
    logic [NUM_EV-1:0] prev;
    logic [NUM_EV-1:0] pend;
    logic [31:0] tmr;
    logic tmr_run;
    logic gstart_prev;
    logic warn31;
    logic [6:0] wr_ptr;
    logic [6:0] count;
    logic [6:0] sel_age;
    logic sel_lcd;
    slogr_led_t [1:0] led;
    logic [7:0] bar_code;
    logic popup;
    logic [31:0] rdata;
  } slogr_state_t;

  // Event index to code; each pair of indices has consecutive codes
  function automatic logic [7:0] slogr_code(input int idx);
    logic [7:0] base;
    case (idx / 2)
      0: base = CODE_GEN_LOST;
      1: base = CODE_TEST;
      2: base = CODE_UNBAL;
      3: base = CODE_NSEQ;
      4: base = CODE_NLOSS;
      5: base = CODE_UV;
      6: base = CODE_OV;
      7: base = CODE_NOV;
      8: base = CODE_UF;
      9: base = CODE_OF;
      default: base = CODE_REC;
    endcase
    return base + 8'(idx % 2);
  endfunction : slogr_code

endpackage : slogr_pkg

// ---- hdl/slogr_top.sv ----
// Source event logger: detection, circular log, LED and display outputs, register port
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
module slogr_top #(
  parameter int READY_WAIT_US = 1000,
  parameter int LOG_DEPTH = slogr_pkg::LOG_DEPTH_DEF,
  parameter int LCD_DEPTH = slogr_pkg::LCD_DEPTH_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire slogr_pkg::slogr_req_t req,
  output logic [31:0] rdata,
  // Source conditions
  input wire slogr_pkg::slogr_src_t [1:0] src,
  input wire logic alt_lost,
  input wire logic gen_start,
  input wire logic gen_ready,
  input wire logic onload_test_fail,
  input wire logic offload_test_fail,
  // Entry context
  input wire logic [31:0] time_now,
  input wire logic [3:0] source_status,
  input wire logic [2:0] transfer_mode,
  // Indication
  output slogr_pkg::slogr_led_t [1:0] led_mode,
  output logic [7:0] bar_code,
  output logic alarm_popup,
  output logic gen_fail_warn,
  output logic [6:0] log_count
);
  import slogr_pkg::*;

  localparam int READY_WAIT_CYC = READY_WAIT_US * CLK_MHZ;

  if (LOG_DEPTH < 2 || LOG_DEPTH > 127 || LCD_DEPTH < 1 || LCD_DEPTH > LOG_DEPTH || READY_WAIT_US < 1)
  begin : g_bad_param
    $error("slogr_top: unsupported parameter values");
  end

  // ==========================================================
  // State
  slogr_state_t s_q;
  slogr_state_t s_d;
  // No reset on purpose; reset clears count and wr_ptr, so old entries are no longer readable
  slogr_entry_t log_mem [LOG_DEPTH];
  logic log_we;
  slogr_entry_t log_wdata;
  logic [NUM_EV-1:0] cond;
  logic [NUM_EV-1:0] edge_set;
  logic [NUM_EV-1:0] en_eff;
  logic tmr_expire;
  logic gen_fail_set;
  logic pick_valid;
  int pick;
  logic [6:0] rd_idx;
  logic rd_valid;
  slogr_entry_t rd_entry;

  // ==========================================================
  // Condition levels per source
  always_comb
  begin
    cond = '0;
    cond[EV_GEN_LOST] = alt_lost;
    cond[EV_ONLOAD] = onload_test_fail;
    cond[EV_OFFLOAD] = offload_test_fail;
    for (int k = 0; k < 2; k++)
    begin
      cond[EV_UNBAL + k] = src[k].connected && (src[k].unbal_pct > s_q.thr);
      cond[EV_NSEQ + k] = src[k].neutral_seq != s_q.nseq_cfg[k];
      cond[EV_NLOSS + k] = src[k].connected && (src[k].unbal_pct > NLOSS_PCT);
      cond[EV_UV + k] = src[k].undervolt;
      cond[EV_OV + k] = src[k].overvolt;
      cond[EV_NOV + k] = src[k].no_volt;
      cond[EV_UF + k] = src[k].underfreq;
      cond[EV_OF + k] = src[k].overfreq;
      cond[EV_REC + k] = src[k].recovered;
    end
  end

  assign en_eff = s_q.en | ALWAYS_MASK;
  assign tmr_expire = s_q.tmr_run && (s_q.tmr == '0);
  assign gen_fail_set = tmr_expire && !gen_ready && en_eff[EV_GEN_FAIL];

  always_comb
  begin
    edge_set = cond & ~s_q.prev & en_eff;
    edge_set[EV_GEN_FAIL] = gen_fail_set;
  end

  // Lowest pending index goes first, one entry per cycle
  always_comb
  begin
    pick = 0;
    pick_valid = 1'b0;
    for (int i = NUM_EV - 1; i >= 0; i--)
    begin
      if (s_q.pend[i])
      begin
        pick = i;
        pick_valid = 1'b1;
      end
    end
  end

  // ==========================================================
  // Log read selection, age zero is the newest entry
  always_comb
  begin
    int t;
    t = int'(s_q.wr_ptr) - 1 - int'(s_q.sel_age);
    if (t < 0)
    begin
      t = t + LOG_DEPTH;
    end
    rd_idx = 7'(t);
    rd_valid = (s_q.sel_age < s_q.count) && (!s_q.sel_lcd || (int'(s_q.sel_age) < LCD_DEPTH));
    rd_entry = log_mem[rd_idx];
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.popup = 1'b0;
    s_d.prev = cond;
    log_we = 1'b0;
    log_wdata = '0;

    // Ready wait timer
    s_d.gstart_prev = gen_start;
    if (gen_start && !s_q.gstart_prev)
    begin
      s_d.tmr_run = 1'b1;
      s_d.tmr = 32'(READY_WAIT_CYC - 1);
    end
    else if (s_q.tmr_run)
    begin
      if (gen_ready || tmr_expire)
      begin
        s_d.tmr_run = 1'b0;
      end
      else
      begin
        s_d.tmr = s_q.tmr - 32'h1;
      end
    end

    // Set wins over clear
    if (src[0].in_range || src[1].in_range)
    begin
      s_d.warn31 = 1'b0;
    end
    if (gen_fail_set)
    begin
      s_d.warn31 = 1'b1;
    end

    // Logging and indication
    if (pick_valid)
    begin
      log_we = 1'b1;
      log_wdata.ts = time_now;
      log_wdata.code = slogr_code(pick);
      log_wdata.src_status = source_status;
      log_wdata.mode = transfer_mode;
      s_d.wr_ptr = (int'(s_q.wr_ptr) == LOG_DEPTH - 1) ? 7'h00 : s_q.wr_ptr + 7'h01;
      if (int'(s_q.count) < LOG_DEPTH)
      begin
        s_d.count = s_q.count + 7'h01;
      end
      if (POPUP_MASK[pick])
      begin
        s_d.popup = 1'b1;
        s_d.bar_code = slogr_code(pick);
      end
      if (OFF_MASK[pick])
      begin
        s_d.led[pick % 2] = SLOGR_LED_OFF;
      end
      if (BLINK_MASK[pick])
      begin
        s_d.led[pick % 2] = SLOGR_LED_BLINK;
      end
      if (ON_MASK[pick])
      begin
        s_d.led[pick % 2] = SLOGR_LED_ON;
      end
    end
    s_d.pend = (s_q.pend & ~(pick_valid ? (NUM_EV'(1) << pick) : '0)) | edge_set;

    // Register writes; nothing here touches the log
    if (req.we)
    begin
      case (req.addr)
        REG_ENABLE: s_d.en = req.wdata[NUM_EV-1:0];
        REG_CFG:
        begin
          s_d.thr = req.wdata[CFG_THR_LSB +: 8];
          s_d.nseq_cfg = req.wdata[CFG_NSEQ_LSB +: 2];
        end
        REG_SEL_LCD:
        begin
          s_d.sel_age = req.wdata[6:0];
          s_d.sel_lcd = 1'b1;
        end
        REG_SEL_MB:
        begin
          s_d.sel_age = req.wdata[6:0];
          s_d.sel_lcd = 1'b0;
        end
        default: s_d.sel_lcd = s_q.sel_lcd;
      endcase
    end

    // Read data stands in the cycle after the strobe only
    s_d.rdata = '0;
    if (req.re)
    begin
      case (req.addr)
        REG_ENABLE: s_d.rdata = 32'(en_eff);
        REG_CFG: s_d.rdata = 32'({s_q.nseq_cfg, s_q.thr});
        REG_STATUS:
        begin
          s_d.rdata[STAT_COUNT_LSB +: 7] = s_q.count;
          s_d.rdata[STAT_WARN31_BIT] = s_q.warn31;
          s_d.rdata[STAT_LED0_LSB +: 2] = s_q.led[0];
          s_d.rdata[STAT_LED1_LSB +: 2] = s_q.led[1];
        end
        REG_SEL_LCD: s_d.rdata = 32'({s_q.sel_lcd, s_q.sel_age});
        REG_SEL_MB: s_d.rdata = 32'({s_q.sel_lcd, s_q.sel_age});
        REG_LOG_TS: s_d.rdata = rd_valid ? rd_entry.ts : 32'h0;
        REG_LOG_INFO:
        begin
          if (rd_valid)
          begin
            s_d.rdata[INFO_CODE_LSB +: 8] = rd_entry.code;
            s_d.rdata[INFO_STAT_LSB +: 4] = rd_entry.src_status;
            s_d.rdata[INFO_MODE_LSB +: 3] = rd_entry.mode;
            s_d.rdata[INFO_VALID_BIT] = 1'b1;
          end
        end
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.en <= ENABLE_RST;
      s_q.thr <= UNBAL_THR_RST;
      s_q.led <= '{SLOGR_LED_OFF, SLOGR_LED_OFF};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (log_we)
    begin
      log_mem[s_q.wr_ptr] <= log_wdata;
    end
  end

  // ==========================================================
  // Outputs
  assign rdata = s_q.rdata;
  assign led_mode = s_q.led;
  assign bar_code = s_q.bar_code;
  assign alarm_popup = s_q.popup;
  assign gen_fail_warn = s_q.warn31;
  assign log_count = s_q.count;

  // ==========================================================
  // Checks
  property p_count_cap;
    @(posedge clk) disable iff (rst) int'(s_q.count) <= LOG_DEPTH;
  endproperty
  a_count_cap: assert property (p_count_cap) else $error("log count above depth");

  property p_wrap;
    @(posedge clk) disable iff (rst) (log_we && int'(s_q.wr_ptr) == LOG_DEPTH - 1) |=> (s_q.wr_ptr == 7'h00);
  endproperty
  a_wrap: assert property (p_wrap) else $error("write pointer did not wrap");

  property p_gen_fail;
    @(posedge clk) disable iff (rst)
      (tmr_expire && !gen_ready && s_q.en[EV_GEN_FAIL]) |=> (s_q.pend[EV_GEN_FAIL] && s_q.warn31);
  endproperty
  a_gen_fail: assert property (p_gen_fail) else $error("generator start failure not raised");

  property p_gen_clear;
    @(posedge clk) disable iff (rst) ((src[0].in_range || src[1].in_range) && !gen_fail_set) |=> !s_q.warn31;
  endproperty
  a_gen_clear: assert property (p_gen_clear) else $error("generator start failure not cleared");

  property p_uv_always;
    @(posedge clk) disable iff (rst) $rose(src[0].undervolt) ##1 s_q.prev[EV_UV] |-> s_q.pend[EV_UV];
  endproperty
  a_uv_always: assert property (p_uv_always) else $error("undervoltage event lost");

  property p_led_off;
    @(posedge clk) disable iff (rst) (log_we && log_wdata.code == CODE_NOV) |=> (led_mode[0] == SLOGR_LED_OFF);
  endproperty
  a_led_off: assert property (p_led_off) else $error("no voltage LED not off");

  property p_blink;
    @(posedge clk) disable iff (rst)
      (log_we && log_wdata.code == CODE_NLOSS) |=> (led_mode[0] == SLOGR_LED_BLINK && $stable(bar_code) && !alarm_popup);
  endproperty
  a_blink: assert property (p_blink) else $error("neutral loss indication wrong");

  property p_popup;
    @(posedge clk) disable iff (rst)
      (log_we && log_wdata.code == CODE_UNBAL) |=> (alarm_popup && bar_code == CODE_UNBAL)
        ##1 (alarm_popup == $past(log_we && POPUP_MASK[pick]));
  endproperty
  a_popup: assert property (p_popup) else $error("alarm screen not popped");

  // Recovery of the second source must light its LED steadily
  property p_led_on;
    @(posedge clk) disable iff (rst)
      (log_we && log_wdata.code == CODE_REC + 8'h01) |=> (led_mode[1] == SLOGR_LED_ON);
  endproperty
  a_led_on: assert property (p_led_on) else $error("recovery LED not on");

  property p_ov_dropped;
    @(posedge clk) disable iff (rst)
      (cond[EV_OV] && !en_eff[EV_OV] && !s_q.pend[EV_OV]) |=> !s_q.pend[EV_OV];
  endproperty
  a_ov_dropped: assert property (p_ov_dropped) else $error("disabled overvoltage event kept");

  property p_nseq;
    @(posedge clk) disable iff (rst)
      ((src[1].neutral_seq != s_q.nseq_cfg[1]) && !s_q.prev[EV_NSEQ + 1] && en_eff[EV_NSEQ + 1])
        |=> s_q.pend[EV_NSEQ + 1];
  endproperty
  a_nseq: assert property (p_nseq) else $error("neutral sequence warning lost");

  property p_lcd_limit;
    @(posedge clk) disable iff (rst)
      (req.re && req.addr == REG_LOG_INFO && s_q.sel_lcd && int'(s_q.sel_age) >= LCD_DEPTH) |=> (rdata == 32'h0);
  endproperty
  a_lcd_limit: assert property (p_lcd_limit) else $error("display path read beyond window");

  property p_count_grow;
    @(posedge clk) disable iff (rst)
      (log_we && int'(s_q.count) < LOG_DEPTH) |=> (s_q.count == $past(s_q.count) + 7'h01);
  endproperty
  a_count_grow: assert property (p_count_grow) else $error("log count did not grow");

endmodule : slogr_top

// ---- tb/slogr_host_model.sv ----
// Register host model standing in for the display panel and the Modbus master
`timescale 1ns/100ps
module slogr_host_model (
  // Clock
  input wire logic clk,
  // Register port
  output slogr_pkg::slogr_req_t req,
  input wire logic [31:0] rdata
);
  import slogr_pkg::*;

  initial
  begin
    req = '0;
  end

  // ==========================================================
  // Bus cycles, one strobe cycle each
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk);
    req.we <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe, so take them at the edge that ends it
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, we: 1'b0, re: 1'b1};
    @(posedge clk);
    req.re <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd

endmodule : slogr_host_model

// ---- tb/tb_top.sv ----
// Self-checking bench of the source event logger
`timescale 1ns/100ps
module tb_top;
  import slogr_pkg::*;

  // ==========================================================
  // Signals
  localparam logic [21:0] OFF_DEF = 22'h0F3331;
  logic clk;
  logic rst;
  slogr_req_t req;
  logic [31:0] rdata;
  slogr_src_t [1:0] src;
  logic alt_lost, gen_start, gen_ready, onload_fail, offload_fail;
  logic [31:0] time_now;
  logic [3:0] source_status;
  logic [2:0] transfer_mode;
  slogr_led_t [1:0] led_mode;
  logic [7:0] bar_code, b0;
  logic alarm_popup, gen_fail_warn;
  logic [6:0] log_count, n0;
  logic [31:0] d;
  int error_cnt = 0;
  int check_count = 0;
  int pop_cnt = 0;
  int p0;
  int cyc = 0;

  slogr_top #(.READY_WAIT_US(2)) dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .src(src),
    .alt_lost(alt_lost), .gen_start(gen_start), .gen_ready(gen_ready), .onload_test_fail(onload_fail),
    .offload_test_fail(offload_fail), .time_now(time_now), .source_status(source_status),
    .transfer_mode(transfer_mode), .led_mode(led_mode), .bar_code(bar_code), .alarm_popup(alarm_popup),
    .gen_fail_warn(gen_fail_warn), .log_count(log_count));

  slogr_host_model host (.clk(clk), .req(req), .rdata(rdata));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Popup is a one-cycle pulse, so count it rather than poll it
  always @(posedge clk)
  begin
    cyc++;
    if (alarm_popup === 1'b1)
      pop_cnt++;
    if (cyc == 10000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  // ==========================================================
  // Helpers
  task end_sim;
    if (error_cnt == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [7:0] ev_code(input int i);
    logic [7:0] base [11];
    base = '{8'h1E, 8'h28, 8'h32, 8'h34, 8'h36, 8'h46, 8'h48, 8'h4A, 8'h4C, 8'h4E, 8'h50};
    return base[i / 2] + 8'(i % 2);
  endfunction : ev_code

  task set_ev(input int i, input logic v);
    case (i)
      0: alt_lost <= v;
      2: onload_fail <= v;
      3: offload_fail <= v;
      4, 5: src[i % 2].unbal_pct <= v ? 8'h0A : 8'h00;
      6, 7: src[i % 2].neutral_seq <= v;
      8, 9: src[i % 2].unbal_pct <= v ? 8'h1E : 8'h00;
      10, 11: src[i % 2].undervolt <= v;
      12, 13: src[i % 2].overvolt <= v;
      14, 15: src[i % 2].no_volt <= v;
      16, 17: src[i % 2].underfreq <= v;
      18, 19: src[i % 2].overfreq <= v;
      default: src[i % 2].recovered <= v;
    endcase
  endtask : set_ev

  task fire(input int i);
    set_ev(i, 1'b1);
    repeat (5) @(posedge clk);
    set_ev(i, 1'b0);
    repeat (2) @(posedge clk);
  endtask : fire

  // ==========================================================
  // Main sequence
  initial
  begin
    rst = 1'b1;
    src = '0;
    src[0].connected = 1'b1;
    src[1].connected = 1'b1;
    {alt_lost, gen_start, gen_ready, onload_fail, offload_fail} = 5'h00;
    time_now = 32'h0;
    source_status = 4'h0;
    transfer_mode = 3'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    host.rd(REG_STATUS, d);
    chk("status", 32'h0, d);
    host.rd(REG_ENABLE, d);
    chk("enable", 32'h0030CCCC, d);
    host.rd(REG_CFG, d);
    chk("cfg", 32'h5, d);
    for (int i = 0; i < 22; i++)
    begin
      if (OFF_DEF[i])
      begin
        fire(i);
        chk("disabled count", 32'h0, 32'(log_count));
      end
    end
    host.wr(REG_ENABLE, 32'h003FFFFF);
    for (int i = 0; i < 22; i++)
    begin
      if (i != 1)
      begin
        n0 = log_count;
        p0 = pop_cnt;
        b0 = bar_code;
        time_now <= 32'h100 + i;
        source_status <= i[3:0];
        transfer_mode <= i[2:0];
        fire(i);
        chk("count", 32'(n0) + ((i == 8 || i == 9) ? 32'h2 : 32'h1), 32'(log_count));
        chk("popups", 32'(p0 + ((i < 10) ? 1 : 0)), 32'(pop_cnt));
        if (i < 8)
          chk("bar", 32'(ev_code(i)), 32'(bar_code));
        else if (i < 10)
          chk("bar", 32'(ev_code(i - 4)), 32'(bar_code));
        else
          chk("bar kept", 32'(b0), 32'(bar_code));
        if (i >= 8)
          chk("led", (i == 14 || i == 15) ? 32'h0 : (i >= 20 ? 32'h1 : 32'h2), 32'(led_mode[i % 2]));
        host.wr(REG_SEL_MB, 32'h0);
        host.rd(REG_LOG_INFO, d);
        chk("info", {1'b1, 12'h000, i[2:0], 4'h0, i[3:0], ev_code(i)}, d);
        host.rd(REG_LOG_TS, d);
        chk("timestamp", 32'h100 + i, d);
      end
    end
    // Threshold raised to 10 and second source neutral setting flipped
    n0 = log_count;
    host.wr(REG_CFG, 32'h0000020A);
    host.rd(REG_CFG, d);
    chk("cfg back", 32'h0000020A, d);
    fire(4);
    src[1].connected <= 1'b0;
    fire(9);
    src[1].connected <= 1'b1;
    chk("cfg count", 32'(n0) + 32'h1, 32'(log_count));
    // Ready wait timer shortened to 250 cycles by the parameter above
    n0 = log_count;
    gen_start <= 1'b1;
    repeat (270) @(posedge clk);
    chk("gen warn", 32'h1, 32'(gen_fail_warn));
    chk("gen count", 32'(n0) + 32'h1, 32'(log_count));
    chk("gen bar", 32'h1F, 32'(bar_code));
    src[1].in_range <= 1'b1;
    repeat (3) @(posedge clk);
    chk("gen warn clear", 32'h0, 32'(gen_fail_warn));
    gen_start <= 1'b0;
    src[1].in_range <= 1'b0;
    @(posedge clk);
    gen_start <= 1'b1;
    gen_ready <= 1'b1;
    repeat (270) @(posedge clk);
    chk("gen ready warn", 32'h0, 32'(gen_fail_warn));
    for (int k = 0; k < 110; k++)
    begin
      time_now <= 32'h1000 + k;
      fire(10);
    end
    chk("full count", 32'h63, 32'(log_count));
    host.wr(REG_STATUS, 32'h0);
    host.wr(REG_LOG_INFO, 32'h0);
    chk("kept count", 32'h63, 32'(log_count));
    host.wr(REG_SEL_MB, 32'h62);
    host.rd(REG_LOG_TS, d);
    chk("oldest ts", 32'h100B, d);
    host.wr(REG_SEL_MB, 32'h63);
    host.rd(REG_LOG_INFO, d);
    chk("beyond depth", 32'h0, d);
    host.wr(REG_SEL_LCD, 32'h13);
    host.rd(REG_LOG_TS, d);
    chk("panel last ts", 32'h105A, d);
    host.wr(REG_SEL_LCD, 32'h14);
    host.rd(REG_LOG_TS, d);
    chk("panel beyond", 32'h0, d);
    host.rd(8'hFC, d);
    chk("unmapped", 32'h0, d);
    end_sim();
  end

endmodule : tb_top
